// >>> rtl/idt_decoder.sv
// Function
// - Take one 14-bit word per instruction
// - Sort into byte, bit, literal/control groups
// - Calls take two cycles
// - Returns take two cycles
// - Jumps, branches and taken skips take two cycles
// - Indirect to program memory adds a cycle
// - Instruction cycle is four oscillator clocks
// - File register always read before write
// - Destination bit: 0 to W, 1 to file
// - File address is seven bits wide
// - Bit operand picks one of eight bits
// - Don't-care opcode bits are ignored
// - Pointer number selects pair zero or one
// - Two-bit pointer update mode
// - Working register is the accumulator
// - Second cycle of a branch is a no-op
`timescale 1ns/10ps
`default_nettype none
module idt_decoder (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [13:0] instr_in,
  input wire logic skip_true_in,
  input wire logic [15:0] file_select_pointer0_in,
  input wire logic [15:0] file_select_pointer1_in,
  output logic fetch_out,
  output logic [1:0] phase_out,
  output logic [1:0] group_out,
  output logic [6:0] file_addr_out,
  output logic [2:0] bit_sel_out,
  output logic dest_file_out,
  output logic dest_working_out,
  output logic ptr_num_out,
  output logic [1:0] pointer_update_mode_out,
  output logic uses_file_out,
  output logic file_read_out,
  output logic file_write_out,
  output logic working_implicit_out,
  output logic exec_nop_out,
  output logic [1:0] cycles_out
);
  typedef enum logic [1:0] {
    IDT_ST_EXEC,
    IDT_ST_EXTRA,
    IDT_ST_FLUSH
  } idt_state_t;

  idt_state_t state_q;
  logic [13:0] instr_q;
  logic [1:0] phase;
  logic cycle_end;
  logic [1:0] cat;
  logic is_byte, is_bit, is_skip_op, is_call_like, is_return, is_branch;
  logic is_movi, ind_hit, ind_prog, writes_file, base_two;
  logic [1:0] cycles_d;

  // Instruction cycle timing from the oscillator
  idt_phase_counter #(.PHASES(idt_pkg::PHASES)) u_phase (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .phase_out(phase),
    .cycle_end_out(cycle_end)
  );

  // Category decode from the current word
  always_comb begin
    cat = instr_q[13:12];
    is_byte = (cat == idt_pkg::CAT_BYTE) &&
      (instr_q[11:8] != 4'h0 || instr_q[7]);
    is_bit = (cat == idt_pkg::CAT_BIT);
    is_skip_op = (is_byte && (instr_q[11:8] == idt_pkg::OP_DEC_SKIP ||
      instr_q[11:8] == idt_pkg::OP_INC_SKIP)) ||
      (is_bit && instr_q[11]);
    is_call_like = (cat == idt_pkg::CAT_CALL && !instr_q[11]) ||
      instr_q == idt_pkg::OP_CALL_W;
    is_return = instr_q == idt_pkg::OP_RETURN ||
      instr_q == idt_pkg::OP_RET_INT ||
      (cat == idt_pkg::CAT_LIT &&
       instr_q[11:8] == idt_pkg::OP_RET_LIT);
    is_branch = (cat == idt_pkg::CAT_CALL && instr_q[11]) ||
      instr_q[13:9] == idt_pkg::OP_REL_BRANCH ||
      instr_q == idt_pkg::OP_BRANCH_W;
    // Indirect moves: pointer number in bit 2, mode in bits 1:0
    is_movi = instr_q[13:7] == idt_pkg::OP_MOVIW_HI &&
      instr_q[6:3] == idt_pkg::OP_MOVIW_MID[3:0];
    writes_file = is_bit || (is_byte && instr_q[idt_pkg::DEST_POS]);
    // Indirect register reach plus program-space pointer
    ind_hit = (is_byte || is_bit) &&
      (instr_q[6:0] == idt_pkg::INDIRECT0_ADDR ||
       instr_q[6:0] == idt_pkg::INDIRECT1_ADDR);
    ind_prog = instr_q[0] ?
      file_select_pointer1_in[idt_pkg::PTR_PROG_BIT] :
      file_select_pointer0_in[idt_pkg::PTR_PROG_BIT];
    base_two = is_call_like || is_return || is_branch ||
      (is_skip_op && skip_true_in);
    cycles_d = 2'h1 + {1'b0, base_two} +
      {1'b0, ind_hit && ind_prog};
  end

  // Capture a new word only at the end of a non-stalled cycle
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      instr_q <= 14'h0000;
    end else if (fetch_out) begin
      instr_q <= instr_in;
    end
  end

  // Extra-cycle sequencer; taken skips, branches, calls and returns flush with a no-op
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= IDT_ST_EXEC;
    end else if (cycle_end) begin
      case (state_q)
        IDT_ST_EXEC: begin
          if (ind_hit && ind_prog) begin
            state_q <= IDT_ST_EXTRA;
          end else if (base_two) begin
            state_q <= IDT_ST_FLUSH;
          end
        end
        IDT_ST_EXTRA: begin
          state_q <= base_two ? IDT_ST_FLUSH : IDT_ST_EXEC;
        end
        default: begin
          state_q <= IDT_ST_EXEC;
        end
      endcase
    end
  end

  // Fetch at the end of the word's last cycle; the held word never
  // re-enters execution, which would replay its extra cycles forever
  assign fetch_out = cycle_end && (state_q == IDT_ST_FLUSH ||
    (state_q == IDT_ST_EXTRA && !base_two) ||
    (state_q == IDT_ST_EXEC && !(ind_hit && ind_prog) && !base_two));

  // Operand fields; unused bits are simply never looked at
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      group_out <= 2'h0;
      file_addr_out <= 7'h00;
      bit_sel_out <= 3'h0;
      dest_file_out <= 1'b1;
      dest_working_out <= 1'b0;
      ptr_num_out <= 1'b0;
      pointer_update_mode_out <= 2'h0;
      uses_file_out <= 1'b0;
      working_implicit_out <= 1'b0;
      cycles_out <= 2'h1;
    end else begin
      group_out <= is_byte ? 2'(idt_pkg::IDT_GRP_BYTE) :
        is_bit ? 2'(idt_pkg::IDT_GRP_BIT) :
        2'(idt_pkg::IDT_GRP_LITCTL);
      file_addr_out <= instr_q[6:0];
      bit_sel_out <= instr_q[9:7];
      dest_file_out <= instr_q[idt_pkg::DEST_POS];
      dest_working_out <= is_byte &&
        !instr_q[idt_pkg::DEST_POS];
      ptr_num_out <= instr_q[idt_pkg::PTR_POS];
      pointer_update_mode_out <= is_movi ? instr_q[1:0] :
        2'h0;
      uses_file_out <= is_byte || is_bit;
      working_implicit_out <= is_byte ||
        cat == idt_pkg::CAT_LIT;
      cycles_out <= cycles_d;
    end
  end

  // Read in phase 1 of every file instruction, store in phase 3 when it writes the file
  assign file_read_out = (is_byte || is_bit) && state_q == IDT_ST_EXEC &&
    phase == 2'h1;
  assign file_write_out = writes_file && state_q == IDT_ST_EXEC &&
    phase == 2'h3;
  assign exec_nop_out = state_q == IDT_ST_FLUSH;
  assign phase_out = phase;
endmodule : idt_decoder
`default_nettype wire

// >>> rtl/idt_phase_counter.sv
`timescale 1ns/10ps
`default_nettype none
module idt_phase_counter #(
  parameter int unsigned PHASES = 4
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  output logic [1:0] phase_out,
  output logic cycle_end_out
);
  logic [1:0] phase_q;

  // Divide the oscillator by four into one instruction cycle
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  assign phase_out = phase_q;
  assign cycle_end_out = (phase_q == 2'(PHASES - 1));
endmodule : idt_phase_counter
`default_nettype wire

// >>> rtl/idt_pkg.sv
package idt_pkg;
  // Instruction word and operand widths
  localparam int unsigned WORD_W = 14;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BITSEL_W = 3;
  localparam int unsigned PHASES = 4;
  localparam int unsigned PHASE_W = 2;
  // Field positions inside the 14-bit word
  localparam int unsigned DEST_POS = 7;
  localparam int unsigned BIT_LSB = 7;
  localparam int unsigned PTR_POS = 2;
  // Indirect file register addresses (pointer 0 and 1)
  localparam logic [6:0] INDIRECT0_ADDR = 7'h00;
  localparam logic [6:0] INDIRECT1_ADDR = 7'h01;
  // Pointer bit that marks program memory space
  localparam int unsigned PTR_PROG_BIT = 15;
  // Opcode category (top two bits)
  localparam logic [1:0] CAT_BYTE = 2'h0;
  localparam logic [1:0] CAT_BIT = 2'h1;
  localparam logic [1:0] CAT_CALL = 2'h2;
  localparam logic [1:0] CAT_LIT = 2'h3;
  // Selected opcodes
  localparam logic [3:0] OP_DEC_SKIP = 4'hB;
  localparam logic [3:0] OP_INC_SKIP = 4'hF;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RET_INT = 14'h0009;
  localparam logic [13:0] OP_CALL_W = 14'h000A;
  localparam logic [13:0] OP_BRANCH_W = 14'h000B;
  localparam logic [6:0] OP_MOVIW_HI = 7'h00;
  localparam logic [4:0] OP_MOVIW_MID = 5'h02;
  localparam logic [3:0] OP_RET_LIT = 4'h4;
  localparam logic [4:0] OP_REL_BRANCH = 5'h19;
  localparam logic [6:0] OP_PTR_IMM = 7'h3F;

  typedef enum logic [1:0] {
    IDT_GRP_BYTE,
    IDT_GRP_BIT,
    IDT_GRP_LITCTL
  } idt_group_t;

  typedef enum logic [1:0] {
    IDT_PRE_INC,
    IDT_PRE_DEC,
    IDT_POST_INC,
    IDT_POST_DEC
  } idt_ptr_mode_t;
endpackage : idt_pkg

// >>> verification/idt_decoder_sva.sv
`timescale 1ns/10ps
`default_nettype none
module idt_decoder_sva (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [13:0] instr_in,
  input wire logic fetch_out,
  input wire logic [1:0] phase_out,
  input wire logic [1:0] group_out,
  input wire logic [6:0] file_addr_out,
  input wire logic [2:0] bit_sel_out,
  input wire logic dest_file_out,
  input wire logic dest_working_out,
  input wire logic ptr_num_out,
  input wire logic [1:0] pointer_update_mode_out,
  input wire logic file_read_out,
  input wire logic file_write_out,
  input wire logic exec_nop_out,
  input wire logic [1:0] cycles_out
);
  // One clock domain, so clocking and reset are stated once
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  a_fetch_phase: assert property (fetch_out |-> phase_out == 2'h3)
    else $error("fetch outside last phase");
  a_phase_wrap: assert property (phase_out == 2'h3 |=> phase_out == 2'h0)
    else $error("phase did not wrap");
  a_read_first: assert property (file_write_out |-> $past(file_read_out, 2))
    else $error("store without earlier read");
  a_bit_field: assert property (fetch_out && instr_in[13:12] == 2'h1 |-> ##2
    group_out == 2'h1 && bit_sel_out == $past(instr_in[9:7], 2)
    && file_addr_out == $past(instr_in[6:0], 2)) else $error("bit decode");
  a_dest_sel: assert property (fetch_out && instr_in[13:8] != 6'h00
    && instr_in[13:12] == 2'h0 |-> ##2 dest_file_out == $past(instr_in[7], 2)
    && dest_working_out != dest_file_out) else $error("destination decode");
  a_long_jump: assert property (fetch_out && instr_in[13:12] == 2'h2
    |-> ##2 cycles_out == 2'h2) else $error("jump cycle count");
  a_ptr_mode: assert property (fetch_out && instr_in[13:3] == 11'h002
    |-> ##2 ptr_num_out == $past(instr_in[2], 2)
    && pointer_update_mode_out == $past(instr_in[1:0], 2)) else $error("pointer");
  a_nop_span: assert property ($rose(exec_nop_out) |-> exec_nop_out [*4])
    else $error("no-op cycle too short");
endmodule : idt_decoder_sva
bind idt_decoder idt_decoder_sva u_idt_decoder_sva (.*);
`default_nettype wire

// >>> verification/idt_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module idt_decoder_tb;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic skip_true_in = 1'b0;
  logic [15:0] fsp0 = 16'h0000;
  logic [15:0] fsp1 = 16'h0000;
  logic [13:0] instr_in;
  logic fetch_out;
  logic [1:0] group_out;
  int err_count = 0;
  int checked = 0;
  int seed = 32'h9ED5;
  int ticks = 0;
  int done = 0;
  logic [3:0] notes [$];
  // Word, then skip, pointer 0 and 1 program bits, cycles, group
  logic [20:0] tab [23] = '{{14'h07A5, 7'h04}, {14'h0103, 7'h04},
    {14'h0100, 7'h04}, {14'h17FF, 7'h05}, {14'h1810, 7'h49},
    {14'h1C10, 7'h05}, {14'h0B90, 7'h48}, {14'h0F90, 7'h04},
    {14'h2123, 7'h0A}, {14'h2923, 7'h0A}, {14'h000A, 7'h0A},
    {14'h000B, 7'h0A}, {14'h0008, 7'h0A}, {14'h0009, 7'h0A},
    {14'h3455, 7'h0A}, {14'h3205, 7'h0A}, {14'h3012, 7'h06},
    {14'h0700, 7'h28}, {14'h0A81, 7'h18}, {14'h0A81, 7'h24},
    {14'h0017, 7'h06}, {14'h0B80, 7'h7C}, {14'h0000, 7'h06}};
  idt_decoder u_idt_decoder (.*, .file_select_pointer0_in(fsp0),
    .file_select_pointer1_in(fsp1), .phase_out(), .file_addr_out(),
    .bit_sel_out(), .dest_file_out(), .dest_working_out(), .ptr_num_out(),
    .pointer_update_mode_out(), .uses_file_out(), .file_read_out(),
    .file_write_out(), .working_implicit_out(), .exec_nop_out(),
    .cycles_out());
  idt_prog_mem u_idt_prog_mem (.clock_in(clock_in), .rstn_in(rstn_in),
    .fetch_in(fetch_out), .instr_out(instr_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %h %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Free-running oscillator clock
  initial forever #5 clock_in = ~clock_in;
  // Load memory, release reset, then set operands of each word just taken
  initial begin
    foreach (u_idt_prog_mem.mem[i]) u_idt_prog_mem.mem[i] = 14'h0000;
    foreach (tab[i]) u_idt_prog_mem.mem[i] = tab[i][20:7];
    repeat (2) @(posedge clock_in);
    #1 rstn_in = 1'b1;
    foreach (tab[i]) begin
      @(posedge clock_in iff fetch_out === 1'b1);
      #1;
      skip_true_in = tab[i][6];
      fsp0 = {tab[i][5], 15'($random(seed))};
      fsp1 = {tab[i][4], 15'($random(seed))};
      notes.push_back(tab[i][3:0]);
    end
  end
  // Time each word from its fetch to the next one and check its group
  initial begin
    int n;
    @(posedge clock_in iff fetch_out === 1'b1);
    forever begin
      n = 0;
      do begin
        @(posedge clock_in);
        n++;
        if (n == 2) check(group_out, notes[0][1:0]);
      end while (fetch_out !== 1'b1);
      check(n, 4 * notes[0][3:2]);
      void'(notes.pop_front());
      done++;
    end
  end
  // Ceiling is far above the roughly 150 clocks the table needs
  always @(posedge clock_in) begin
    ticks++;
    if (done == 23) print_verdict();
    else if (ticks == 3000) begin
      err_count++;
      print_verdict();
    end
  end
endmodule : idt_decoder_tb
`default_nettype wire

// >>> verification/idt_prog_mem.sv
`timescale 1ns/10ps
`default_nettype none
module idt_prog_mem (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic fetch_in,
  output logic [13:0] instr_out
);
  logic [13:0] mem [32];
  logic [4:0] addr_q;
  // Step to the next word at each fetch
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) addr_q <= 5'h00;
    else if (fetch_in) addr_q <= addr_q + 5'h01;
  end
  // Inverse outside a fetch, so a word taken at the wrong edge shows up
  assign instr_out = fetch_in ? mem[addr_q] : ~mem[addr_q];
endmodule : idt_prog_mem
`default_nettype wire
